/* common/fspp_cfg.svh */
// Constants of the flash serial programming port.
`ifndef FSPP_CFG_SVH
`define FSPP_CFG_SVH
`define FSPP_CELL_BIT 23
`define FSPP_DIR_BIT 16
`define FSPP_ADDR_MSB 19
`define FSPP_LOCKED_BYTE 8'h00
`define FSPP_ERASED_BYTE 8'hff
`define FSPP_OPT_LO 20'h0003c
`define FSPP_OPT_HI 20'h0003f
`define FSPP_PROG_US 30
`define FSPP_CLK_MHZ 20
`define FSPP_PROG_CYC (`FSPP_PROG_US * `FSPP_CLK_MHZ)
`endif

/* common/fspp_pkg.sv */
// Types of the flash serial programming port.
package fspp_pkg;
  typedef enum logic [3:0] {
    FSPP_IDLE = 4'b0001,
    FSPP_ADDR = 4'b0010,
    FSPP_WDATA = 4'b0100,
    FSPP_RDATA = 4'b1000
  } fspp_state_t;
  typedef enum logic [1:0] {
    FSPP_OP_READ = 2'h0,
    FSPP_OP_PROG = 2'h1,
    FSPP_OP_ERASE = 2'h2
  } fspp_op_t;
endpackage

/* src/fspp_sync.sv */
// Two-stage synchroniser for the serial pins and mode pins.
`timescale 1ns/10ps
module fspp_sync (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Level in and out.
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

/* src/fspp_edges.sv */
// Finds clock edges and inverted start and stop on the synchronised lines.
`timescale 1ns/10ps
`include "fspp_cfg.svh"
module fspp_edges (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Synchronised lines.
  input wire logic scl,
  input wire logic sda,
  // Events, one cycle each.
  output logic clk_rise,
  output logic clk_fall,
  output logic start_seen,
  output logic stop_seen
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  always_comb begin
    clk_rise = scl & ~scl_q;
    clk_fall = ~scl & scl_q;
    start_seen = scl & scl_q & sda & ~sda_q;
    stop_seen = scl & scl_q & ~sda & sda_q;
  end
endmodule

/* src/fspp_port.sv */
// Slave side of the serial flash programming port with flash control outputs.
`timescale 1ns/10ps
`include "fspp_cfg.svh"
module fspp_port
  import fspp_pkg::*;
(
  // Clock and chip reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Programming pins.
  input wire logic tool_reset_n,
  input wire logic test_mode_pin,
  input wire logic serial_clock,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_n,
  // Flash array interface.
  output logic flash_req,
  output logic [1:0] flash_op,
  output logic flash_secondary,
  output logic [19:0] flash_addr,
  output logic [7:0] flash_wdata,
  input wire logic [7:0] flash_rdata,
  input wire logic read_lock,
  // Status.
  output logic tool_mode,
  output logic prog_busy
);
  logic scl_s;
  logic sda_s;
  logic rst_s;
  logic tst_s;
  logic clk_rise;
  logic clk_fall;
  logic start_seen;
  logic stop_seen;
  fspp_state_t state;
  logic [23:0] cmd;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [1:0] bytecnt;
  logic first_wbyte;
  logic [15:0] busy_cnt;
  logic mode_ok;
  logic in_dummy;

  fspp_sync u_sync_scl (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(serial_clock), .sync_out(scl_s));
  fspp_sync u_sync_sda (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(serial_data_line_in), .sync_out(sda_s));
  fspp_sync u_sync_rst (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(tool_reset_n), .sync_out(rst_s));
  fspp_sync u_sync_tst (.clk_sys(clk_sys), .rst_n(rst_n), .async_in(test_mode_pin), .sync_out(tst_s));

  fspp_edges u_edges (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .scl(scl_s),
    .sda(sda_s),
    .clk_rise(clk_rise),
    .clk_fall(clk_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  ////////////////////////////////////////////////////////////////////////
  // Mode gating.

  // Tool mode needs reset held low and the test pin high together.
  assign mode_ok = ~rst_s & tst_s;
  assign in_dummy = (bitcnt == 4'h9);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tool_mode <= 1'b0;
    end else begin
      tool_mode <= mode_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Protocol state machine.

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= FSPP_IDLE;
    end else if (!mode_ok || stop_seen) begin
      state <= FSPP_IDLE;
    end else if (start_seen) begin
      state <= FSPP_ADDR;
    end else if (state == FSPP_ADDR && clk_fall && in_dummy && bytecnt == 2'h2) begin
      state <= cmd[`FSPP_DIR_BIT] ? FSPP_RDATA : FSPP_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit counting: eight data bits then one dummy clock.
  // Rises are counted, so the falling edge that follows a start is not taken for a bit.

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bitcnt <= 4'h0;
      bytecnt <= 2'h0;
    end else if (start_seen || state == FSPP_IDLE) begin
      bitcnt <= 4'h0;
      bytecnt <= 2'h0;
    end else if (clk_rise && bitcnt != 4'h9) begin
      bitcnt <= bitcnt + 4'h1;
    end else if (clk_fall && in_dummy) begin
      bitcnt <= 4'h0;
      if (bytecnt != 2'h3) begin
        bytecnt <= bytecnt + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive shifting, MSB first.

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= 8'h00;
      cmd <= 24'h000000;
    end else if (start_seen) begin
      cmd <= 24'h000000;
    end else if (clk_rise && bitcnt < 4'h8) begin
      shreg <= {shreg[6:0], sda_s};
      if (state == FSPP_ADDR) begin
        cmd <= {cmd[22:0], sda_s};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flash requests and address stepping.

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flash_req <= 1'b0;
      flash_op <= FSPP_OP_READ;
      flash_secondary <= 1'b0;
      flash_addr <= 20'h00000;
      flash_wdata <= 8'h00;
      first_wbyte <= 1'b0;
    end else begin
      flash_req <= 1'b0;
      if (state == FSPP_ADDR && clk_fall && in_dummy && bytecnt == 2'h2) begin
        flash_secondary <= cmd[`FSPP_CELL_BIT];
        flash_addr <= cmd[`FSPP_ADDR_MSB:0];
        first_wbyte <= 1'b1;
        if (cmd[`FSPP_DIR_BIT]) begin
          flash_op <= FSPP_OP_READ;
          flash_req <= 1'b1;
        end
      end else if (state == FSPP_WDATA && clk_fall && in_dummy) begin
        // A secondary-cell write whose cmd[15:8] is not 0x0e (such as 0x5515) is the chip erase,
        // the only erase this port offers; sector erase stays with software.
        if (flash_secondary && cmd[15:8] != 8'h0e) begin
          if (first_wbyte) begin
            flash_op <= FSPP_OP_ERASE;
            flash_req <= 1'b1;
          end
        end else if (shreg != `FSPP_ERASED_BYTE || first_wbyte) begin
          // Trailing 0xff needs no programming; the last data byte was requested at its own dummy.
          flash_op <= FSPP_OP_PROG;
          flash_req <= 1'b1;
        end
        flash_wdata <= shreg;
        first_wbyte <= 1'b0;
        if (!first_wbyte) begin
          flash_addr <= flash_addr + 20'h00001;
        end
      end else if (state == FSPP_WDATA && first_wbyte == 1'b0 && flash_req) begin
        flash_addr <= flash_addr;
      end else if (state == FSPP_RDATA && clk_fall && in_dummy) begin
        flash_addr <= flash_addr + 20'h00001;
        flash_op <= FSPP_OP_READ;
        flash_req <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Programming time guard for observers.

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 16'h0000;
      prog_busy <= 1'b0;
    end else if (flash_req && flash_op != FSPP_OP_READ) begin
      busy_cnt <= 16'(`FSPP_PROG_CYC);
      prog_busy <= 1'b1;
    end else if (busy_cnt != 16'h0000) begin
      busy_cnt <= busy_cnt - 16'h0001;
      prog_busy <= (busy_cnt != 16'h0001);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data drive: device drives the eight bit periods, never the dummy.

  logic [7:0] rd_byte;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_byte <= 8'h00;
      serial_data_line_out <= 1'b1;
      serial_data_line_oe_n <= 1'b1;
    end else if (state != FSPP_RDATA || !mode_ok || stop_seen) begin
      serial_data_line_out <= 1'b1;
      serial_data_line_oe_n <= 1'b1;
    end else if (flash_req && flash_op == FSPP_OP_READ) begin
      // The first bit goes out at once, while the clock is still low after the dummy.
      rd_byte <= read_lock ? `FSPP_LOCKED_BYTE : flash_rdata;
      serial_data_line_out <= read_lock ? 1'b0 : flash_rdata[7];
      serial_data_line_oe_n <= 1'b0;
    end else if (clk_fall) begin
      if (bitcnt == 4'h8) begin
        serial_data_line_oe_n <= 1'b1;
      end else if (bitcnt != 4'h0 && !in_dummy) begin
        serial_data_line_out <= rd_byte[3'h7 - bitcnt[2:0]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  a_no_ack_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state != FSPP_RDATA) |=> serial_data_line_oe_n)
    else $error("data line driven outside a read");
  a_idle_on_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stop_seen |=> state == FSPP_IDLE)
    else $error("stop did not return to idle");
  a_idle_no_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !mode_ok |=> state == FSPP_IDLE)
    else $error("protocol active outside tool mode");
  a_start_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (start_seen && mode_ok && !stop_seen) |=> state == FSPP_ADDR)
    else $error("start not taken");
  a_lock_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (read_lock && flash_req && flash_op == FSPP_OP_READ && state == FSPP_RDATA && !clk_fall && mode_ok && !stop_seen)
      |=> rd_byte == 8'h00)
    else $error("locked read returned data");
  a_read_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == FSPP_RDATA && clk_fall && in_dummy && mode_ok && !stop_seen)
      |=> flash_addr == $past(flash_addr) + 20'h00001)
    else $error("read address not stepped");
  a_dir_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == FSPP_ADDR && $past(state) == FSPP_ADDR) ##1 (state == FSPP_RDATA) |-> cmd[16])
    else $error("read entered with write direction");
  a_busy_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (flash_req && flash_op == FSPP_OP_PROG) |=> prog_busy [*8])
    else $error("program busy too short");
endmodule

/* testbench/fspp_tool_model.sv */
// Programming tool model: master of the serial link, driving clock and data.
`timescale 1ns/10ps
`include "fspp_cfg.svh"
module fspp_tool_model #(
  parameter int GAP_CYC = `FSPP_PROG_CYC
) (
  // System clock used to pace the link.
  input wire logic clk_sys,
  // Serial pins.
  output logic serial_clock,
  output logic sda_drv,
  input wire logic sda_wire
);
  logic last_lvl;
  initial begin
    serial_clock = 1'b0;
    sda_drv = 1'b0;
    last_lvl = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic put(input logic v);
    sda_drv <= v;
    last_lvl <= v;
  endtask
  task automatic start();
    serial_clock <= 1'b0;
    put(1'b0);
    tick(2);
    serial_clock <= 1'b1;
    tick(2);
    put(1'b1);
    tick(4);
  endtask
  task automatic send_byte(input logic [7:0] b, input logic stop_in_dummy);
    for (int i = 7; i >= 0; i--) begin
      serial_clock <= 1'b0;
      tick(2);
      put(b[i]);
      tick(2);
      serial_clock <= 1'b1;
      tick(4);
    end
    serial_clock <= 1'b0;
    tick(2);
    put(1'b1);
    tick(2);
    serial_clock <= 1'b1;
    tick(2);
    if (stop_in_dummy) begin
      put(1'b0);
    end
    tick(2);
    // Programming needs the full spacing before the next dummy clock.
    tick(GAP_CYC);
  endtask
  task automatic read_byte(output logic [7:0] b, input logic stop_in_dummy);
    for (int i = 7; i >= 0; i--) begin
      serial_clock <= 1'b0;
      tick(2);
      // A released line shows the inverse of the last level, not a held copy.
      sda_drv <= ~last_lvl;
      tick(2);
      serial_clock <= 1'b1;
      tick(4);
      b[i] = sda_wire;
    end
    serial_clock <= 1'b0;
    tick(2);
    put(1'b1);
    tick(2);
    serial_clock <= 1'b1;
    tick(2);
    // After a read the device owns the line in the next bit, so stop lands here.
    if (stop_in_dummy) begin
      put(1'b0);
    end
    tick(2);
  endtask
  task automatic stop();
    serial_clock <= 1'b0;
    tick(2);
    put(1'b1);
    tick(2);
    serial_clock <= 1'b1;
    tick(2);
    put(1'b0);
    tick(4);
  endtask
endmodule

/* testbench/flash_serial_programming_port_tb_top.sv */
// Self-checking bench for the serial flash programming port.
`timescale 1ns/10ps
module flash_serial_programming_port_tb_top;
  import fspp_pkg::*;
  logic clk_sys, rst_n, tool_reset_n, test_mode_pin, read_lock;
  logic serial_clock, tool_sda, sda_out, sda_oe_n, sda_in;
  logic flash_req, flash_secondary, tool_mode, prog_busy;
  logic [1:0] flash_op;
  logic [19:0] flash_addr;
  logic [7:0] flash_wdata, flash_rdata, rb;
  logic [30:0] req_q[$];
  int fails, checks_done;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  assign sda_in = (sda_oe_n === 1'b0) ? sda_out : tool_sda;
  assign flash_rdata = flash_addr[7:0] ^ 8'h5a;
  always @(posedge clk_sys) begin
    if (flash_req === 1'b1) begin
      req_q.push_back({flash_op, flash_secondary, flash_addr, flash_wdata});
    end
  end
  fspp_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .tool_reset_n(tool_reset_n),
    .test_mode_pin(test_mode_pin), .serial_clock(serial_clock), .serial_data_line_in(sda_in),
    .serial_data_line_out(sda_out), .serial_data_line_oe_n(sda_oe_n), .flash_req(flash_req),
    .flash_op(flash_op), .flash_secondary(flash_secondary), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_rdata(flash_rdata), .read_lock(read_lock),
    .tool_mode(tool_mode), .prog_busy(prog_busy));
  fspp_tool_model tool_u (.clk_sys(clk_sys), .serial_clock(serial_clock), .sda_drv(tool_sda),
    .sda_wire(sda_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr_txn(input logic [23:0] a, input logic [15:0] d, input int n);
    req_q.delete();
    tool_u.start();
    for (int i = 0; i < 3; i++) tool_u.send_byte(a[23-8*i -: 8], 1'b0);
    for (int i = 0; i < n; i++) tool_u.send_byte(d[15-8*i -: 8], 1'b0);
    tool_u.send_byte(8'hff, 1'b1);
    repeat (20) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_refused();
    tool_reset_n <= 1'b0;
    wr_txn(24'h000010, 16'h1100, 1);
    check("tool_mode", tool_mode, 1'b0);
    check("req count", req_q.size(), 0);
    $display("refused test done");
  endtask
  task automatic t_program();
    test_mode_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("tool_mode", tool_mode, 1'b1);
    wr_txn(24'h000012, 16'ha53c, 2);
    check("req count", req_q.size(), 2);
    check("first req", req_q[0], {FSPP_OP_PROG, 1'b0, 20'h00012, 8'ha5});
    check("second req", req_q[1], {FSPP_OP_PROG, 1'b0, 20'h00013, 8'h3c});
    check("busy done", prog_busy, 1'b0);
    $display("program test done");
  endtask
  task automatic t_read();
    for (int lk = 0; lk < 2; lk++) begin
      read_lock <= lk[0];
      tool_u.start();
      tool_u.send_byte(8'h01, 1'b0);
      tool_u.send_byte(8'h00, 1'b0);
      tool_u.send_byte(8'h40, 1'b0);
      for (int i = 0; i < 2; i++) begin
        tool_u.read_byte(rb, i == 1);
        check("read byte", rb, lk ? 8'h00 : (8'h40 + i) ^ 8'h5a);
      end
      repeat (8) @(posedge clk_sys);
      check("released", sda_oe_n, 1'b1);
    end
    read_lock <= 1'b0;
    $display("read test done");
  endtask
  task automatic t_secondary();
    wr_txn(24'h805515, 16'haa00, 1);
    check("erase count", req_q.size(), 1);
    check("erase req", req_q[0][30:28], {FSPP_OP_ERASE, 1'b1});
    wr_txn(24'h800e3c, 16'h0000, 1);
    check("option req", {req_q[0][30:28], req_q[0][7:0]}, {FSPP_OP_PROG, 1'b1, 8'h00});
    $display("secondary test done");
  endtask
  task automatic t_mode_loss();
    tool_u.start();
    tool_u.send_byte(8'h00, 1'b0);
    test_mode_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check("tool_mode", tool_mode, 1'b0);
    test_mode_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    wr_txn(24'h000020, 16'h7700, 1);
    check("req count", req_q.size(), 1);
    check("req", req_q[0], {FSPP_OP_PROG, 1'b0, 20'h00020, 8'h77});
    $display("mode loss test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    tool_reset_n = 1'b1;
    test_mode_pin = 1'b0;
    read_lock = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    t_refused();
    t_program();
    t_read();
    t_secondary();
    t_mode_loss();
    report_and_stop();
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    report_and_stop();
  end
endmodule
